// file: usb_dev_params.svh
// constants for the usb device state control block
`ifndef USB_DEV_PARAMS_SVH
`define USB_DEV_PARAMS_SVH
`define UDSC_CLK_MHZ 20
`define UDSC_SUSPEND_IDLE_US 3000
`define UDSC_SUSPEND_IDLE_CYC (`UDSC_SUSPEND_IDLE_US * `UDSC_CLK_MHZ)
`define UDSC_ADDR_W 7
`define UDSC_NUM_EP 4
`define UDSC_EP_TYPE_W 3
`define UDSC_IRQ_W 3
`define UDSC_IRQ_SUSPEND 0
`define UDSC_IRQ_RESUME 1
`define UDSC_IRQ_BUS_RESET_END 2
`define UDSC_IRQ_MASK_RST 3'h0
`define UDSC_ADDR_RST 7'h00
`define UDSC_TXV_DIS_RST 1'b1
`endif

// file: usb_dev_pkg.sv
// types for the usb device state control block
package usb_dev_pkg;
  typedef enum logic [2:0] {
    ST_POWERED    = 3'h0,
    ST_DEFAULT    = 3'h1,
    ST_ADDRESS    = 3'h2,
    ST_CONFIGURED = 3'h3,
    ST_SUSPENDED  = 3'h4
  } dev_state_t;
endpackage : usb_dev_pkg

// file: resume_catch.sv
// asynchronous resume catcher with two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module resume_catch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_wake,
  input wire logic clear,
  output logic resume_seen
);
  logic catch_r;
  logic sync1_r;
  logic sync2_r;

  // caught without any clock, so it works with clocks stopped
  always_ff @(posedge clk or posedge bus_wake) begin
    if (bus_wake) begin
      catch_r <= 1'b1;
    end else if (sys_rst || clear) begin
      catch_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= catch_r;
      sync2_r <= sync1_r;
    end
  end

  assign resume_seen = sync2_r;
endmodule : resume_catch
`default_nettype wire

// file: usb_device_state_control.sv
// usb device port state control: default, address, configured, suspend
`timescale 1ns/1ps
`default_nettype none
`include "usb_dev_params.svh"
module usb_device_state_control #(
  parameter int NUM_EP = `UDSC_NUM_EP,
  parameter int SUSPEND_IDLE_CYC = `UDSC_SUSPEND_IDLE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_clock_en,
  input wire logic bus_activity,
  input wire logic bus_reset_in,
  input wire logic tok_valid,
  input wire logic [`UDSC_ADDR_W-1:0] tok_addr,
  input wire logic global_state_wr,
  input wire logic addressed_state_enable_in,
  input wire logic configured_in,
  input wire logic function_address_wr,
  input wire logic [`UDSC_ADDR_W-1:0] function_address_in,
  input wire logic function_enable_in,
  input wire logic endpoint_wr,
  input wire logic [$clog2(NUM_EP)-1:0] endpoint_sel,
  input wire logic endpoint_enable_in,
  input wire logic [`UDSC_EP_TYPE_W-1:0] endpoint_type_in,
  input wire logic irq_mask_wr,
  input wire logic [`UDSC_IRQ_W-1:0] irq_mask_in,
  input wire logic irq_clear_wr,
  input wire logic [`UDSC_IRQ_W-1:0] irq_clear_in,
  input wire logic transceiver_ctrl_wr,
  input wire logic transceiver_disable_in,
  output usb_dev_pkg::dev_state_t dev_state_r,
  output logic [`UDSC_IRQ_W-1:0] irq_status_r,
  output logic [`UDSC_IRQ_W-1:0] irq_mask_r,
  output logic irq_r,
  output logic addressed_state_enable_r,
  output logic configured_r,
  output logic [`UDSC_ADDR_W-1:0] function_address_r,
  output logic function_enable_r,
  output logic [NUM_EP-1:0] endpoint_enable_r,
  output logic [NUM_EP*`UDSC_EP_TYPE_W-1:0] endpoint_type_r,
  output logic transceiver_disable_r,
  output logic tok_accept_r
);
  import usb_dev_pkg::*;

  localparam int CNT_W = $clog2(SUSPEND_IDLE_CYC + 1);
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(SUSPEND_IDLE_CYC - 1);

  logic act_s1_r;
  logic act_s2_r;
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_s3_r;
  logic [CNT_W-1:0] idle_cnt_r;
  dev_state_t back_state_r;
  dev_state_t state_nxt;
  logic [`UDSC_IRQ_W-1:0] status_nxt;
  logic [`UDSC_IRQ_W-1:0] set_evt;
  logic resume_seen;

  function automatic logic ep_hit(input logic [$clog2(NUM_EP)-1:0] sel, input int idx);
    ep_hit = (sel == idx[$clog2(NUM_EP)-1:0]);
  endfunction : ep_hit

  // writes only land while the master clock reaches the port
  wire wr_ok = master_clock_en;
  wire reset_end_evt = rst_s3_r && !rst_s2_r;
  wire idle_ready = (dev_state_r != ST_POWERED) && (dev_state_r != ST_SUSPENDED);
  wire suspend_evt = idle_ready && !act_s2_r && (idle_cnt_r == IDLE_LAST);
  wire resume_evt = (dev_state_r == ST_SUSPENDED) && resume_seen;
  wire [`UDSC_IRQ_W-1:0] clear_req = (wr_ok && irq_clear_wr) ? irq_clear_in : `UDSC_IRQ_MASK_RST;
  wire suspend_ack = clear_req[`UDSC_IRQ_SUSPEND] && irq_status_r[`UDSC_IRQ_SUSPEND];
  wire tok_hit = addressed_state_enable_r ?
                 (function_enable_r && tok_addr == function_address_r) :
                 (tok_addr == `UDSC_ADDR_RST);

  resume_catch u_resume (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_wake(bus_activity),
    .clear(dev_state_r != ST_SUSPENDED),
    .resume_seen(resume_seen)
  );

  always_comb begin
    set_evt = `UDSC_IRQ_MASK_RST;
    set_evt[`UDSC_IRQ_SUSPEND] = suspend_evt;
    set_evt[`UDSC_IRQ_RESUME] = resume_evt;
    set_evt[`UDSC_IRQ_BUS_RESET_END] = reset_end_evt;
    // a new event beats a clear in the same cycle
    status_nxt = set_evt | (irq_status_r & ~clear_req);
  end

  always_comb begin
    state_nxt = dev_state_r;
    case (dev_state_r)
      ST_POWERED: state_nxt = ST_POWERED;
      ST_DEFAULT: if (addressed_state_enable_r && function_enable_r) state_nxt = ST_ADDRESS;
      ST_ADDRESS: begin
        if (!addressed_state_enable_r) state_nxt = ST_DEFAULT;
        else if (configured_r) state_nxt = ST_CONFIGURED;
      end
      ST_CONFIGURED: if (!configured_r) state_nxt = ST_ADDRESS;
      ST_SUSPENDED: if (resume_evt) state_nxt = back_state_r;
      default: state_nxt = ST_POWERED;
    endcase
    if (suspend_ack && dev_state_r != ST_SUSPENDED) state_nxt = ST_SUSPENDED;
    if (reset_end_evt) state_nxt = ST_DEFAULT;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      act_s1_r <= 1'b0;
      act_s2_r <= 1'b0;
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
      rst_s3_r <= 1'b0;
    end else begin
      act_s1_r <= bus_activity;
      act_s2_r <= act_s1_r;
      rst_s1_r <= bus_reset_in;
      rst_s2_r <= rst_s1_r;
      rst_s3_r <= rst_s2_r;
    end
  end

  // counter holds one past IDLE_LAST so the flag is raised once per idle span
  always_ff @(posedge clk) begin
    if (sys_rst || act_s2_r || !idle_ready) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != IDLE_LAST + CNT_W'(1)) begin
      idle_cnt_r <= idle_cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dev_state_r <= ST_POWERED;
      back_state_r <= ST_DEFAULT;
      irq_status_r <= `UDSC_IRQ_MASK_RST;
      irq_r <= 1'b0;
      tok_accept_r <= 1'b0;
    end else begin
      dev_state_r <= state_nxt;
      if (suspend_ack && dev_state_r != ST_SUSPENDED) back_state_r <= dev_state_r;
      irq_status_r <= status_nxt;
      // bus reset end is not maskable
      irq_r <= |(irq_status_r & irq_mask_r) || irq_status_r[`UDSC_IRQ_BUS_RESET_END];
      tok_accept_r <= tok_valid && tok_hit && (dev_state_r != ST_POWERED);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || reset_end_evt) begin
      irq_mask_r <= `UDSC_IRQ_MASK_RST;
      addressed_state_enable_r <= 1'b0;
      configured_r <= 1'b0;
      function_address_r <= `UDSC_ADDR_RST;
      function_enable_r <= 1'b0;
    end else if (wr_ok) begin
      if (irq_mask_wr) irq_mask_r <= irq_mask_in;
      if (global_state_wr) begin
        addressed_state_enable_r <= addressed_state_enable_in;
        configured_r <= configured_in;
      end
      if (function_address_wr) begin
        function_address_r <= function_address_in;
        function_enable_r <= function_enable_in;
      end
    end
  end

  // software may keep the transceiver off through a bus reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      transceiver_disable_r <= `UDSC_TXV_DIS_RST;
    end else if (wr_ok && transceiver_ctrl_wr) begin
      transceiver_disable_r <= transceiver_disable_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_ep
      always_ff @(posedge clk) begin
        if (sys_rst || reset_end_evt) begin
          endpoint_enable_r[gi] <= 1'b0;
          endpoint_type_r[gi*`UDSC_EP_TYPE_W +: `UDSC_EP_TYPE_W] <= '0;
        end else if (wr_ok && endpoint_wr && ep_hit(endpoint_sel, gi)) begin
          endpoint_enable_r[gi] <= endpoint_enable_in;
          endpoint_type_r[gi*`UDSC_EP_TYPE_W +: `UDSC_EP_TYPE_W] <= endpoint_type_in;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_SUSPEND_FLAG_SET: assert property (
    suspend_evt |=> irq_status_r[`UDSC_IRQ_SUSPEND]
  ) else $error("suspend flag not set after idle limit");

  AST_SUSPEND_IRQ_MASKED: assert property (
    irq_r |-> $past(|(irq_status_r & irq_mask_r) || irq_status_r[`UDSC_IRQ_BUS_RESET_END])
  ) else $error("interrupt raised without an enabled cause");

  AST_SUSPEND_IRQ_RAISED: assert property (
    irq_status_r[`UDSC_IRQ_SUSPEND] && irq_mask_r[`UDSC_IRQ_SUSPEND] |=> irq_r
  ) else $error("enabled suspend flag did not raise the interrupt");

  AST_SUSPEND_ACK: assert property (
    suspend_ack && !suspend_evt && !reset_end_evt && dev_state_r != ST_SUSPENDED
    |=> !irq_status_r[`UDSC_IRQ_SUSPEND] && dev_state_r == ST_SUSPENDED
  ) else $error("suspend acknowledge did not clear flag and suspend");

  AST_RESUME_EXIT: assert property (
    dev_state_r == ST_SUSPENDED && bus_activity |-> ##[1:4] dev_state_r != ST_SUSPENDED
  ) else $error("resume not seen within four cycles");

  AST_TXV_WRITE: assert property (
    wr_ok && transceiver_ctrl_wr |=> transceiver_disable_r == $past(transceiver_disable_in)
  ) else $error("transceiver disable not updated");

  AST_WRITE_GATED: assert property (
    !master_clock_en && !reset_end_evt |=> $stable(irq_mask_r) && $stable(function_address_r)
  ) else $error("write took effect with master clock off");

  AST_BUS_RESET_END: assert property (
    reset_end_evt |=> irq_status_r[`UDSC_IRQ_BUS_RESET_END] && dev_state_r == ST_DEFAULT ##1 irq_r
  ) else $error("bus reset end not flagged");

  AST_BUS_RESET_CLEARS: assert property (
    reset_end_evt |=> irq_mask_r == `UDSC_IRQ_MASK_RST && endpoint_enable_r == '0
  ) else $error("bus reset end did not clear mask and endpoints");

  AST_TOKEN_FILTER: assert property (
    tok_valid && !addressed_state_enable_r && tok_addr != `UDSC_ADDR_RST |=> !tok_accept_r
  ) else $error("token for nonzero address answered before addressing");

  COV_ADDRESS: cover property (dev_state_r == ST_DEFAULT ##1 dev_state_r == ST_ADDRESS);
  COV_CONFIGURED: cover property (dev_state_r == ST_ADDRESS ##1 dev_state_r == ST_CONFIGURED);
  COV_SUSPEND: cover property (suspend_evt ##[1:20] dev_state_r == ST_SUSPENDED);
  COV_RESUME: cover property (dev_state_r == ST_SUSPENDED ##1 dev_state_r == ST_CONFIGURED);
endmodule : usb_device_state_control
`default_nettype wire

// file: host_model.sv
// behavioural usb host: bus activity, bus reset and tokens
`timescale 1ns/1ps
`default_nettype none
`include "usb_dev_params.svh"
module host_model (
  input wire logic clk,
  output logic bus_activity,
  output logic bus_reset_in,
  output logic tok_valid,
  output logic [`UDSC_ADDR_W-1:0] tok_addr
);
  initial begin
    bus_activity = 1'b1;
    bus_reset_in = 1'b0;
    tok_valid = 1'b0;
    tok_addr = 7'h55;
  end
  // reset held for ten cycles, then released
  task bus_reset();
    @(posedge clk);
    bus_reset_in <= 1'b1;
    repeat (10) @(posedge clk);
    bus_reset_in <= 1'b0;
  endtask : bus_reset
  // address is inverted once the token is gone so stale values never match
  task token(input logic [`UDSC_ADDR_W-1:0] a);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_addr <= a;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_addr <= ~a;
  endtask : token
  task set_activity(input logic act);
    @(posedge clk);
    bus_activity <= act;
  endtask : set_activity
endmodule : host_model
`default_nettype wire

// file: usb_device_state_control_tb_top.sv
// testbench: software port sequences against the state control block
`timescale 1ns/1ps
`default_nettype none
module usb_device_state_control_tb_top;
  import usb_dev_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mce = 1'b1;
  logic [5:0] wr_v = 6'h00;
  logic aen = 1'b0, cfg = 1'b0, function_enable = 1'b0, een = 1'b0, txd = 1'b1;
  logic [6:0] fa = 7'h00;
  logic [1:0] esel = 2'h0;
  logic [2:0] etype = 3'h0, mask_in = 3'h0, clr_in = 3'h0;
  wire logic act, brst, tv, acc, irq, aen_r, cfg_r, fen_r, txd_r;
  wire logic [6:0] ta, fa_r;
  wire logic [2:0] st_r, mask_r;
  wire logic [3:0] een_r;
  wire logic [11:0] ety_r;
  dev_state_t state;
  int fails = 0;
  int comparisons = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  host_model host_u (.clk(clk), .bus_activity(act), .bus_reset_in(brst), .tok_valid(tv),
    .tok_addr(ta));
  usb_device_state_control #(.NUM_EP(4), .SUSPEND_IDLE_CYC(20)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .master_clock_en(mce), .bus_activity(act), .bus_reset_in(brst),
    .tok_valid(tv), .tok_addr(ta), .global_state_wr(wr_v[0]),
    .addressed_state_enable_in(aen), .configured_in(cfg), .function_address_wr(wr_v[1]),
    .function_address_in(fa), .function_enable_in(function_enable), .endpoint_wr(wr_v[2]),
    .endpoint_sel(esel), .endpoint_enable_in(een), .endpoint_type_in(etype),
    .irq_mask_wr(wr_v[3]), .irq_mask_in(mask_in), .irq_clear_wr(wr_v[4]),
    .irq_clear_in(clr_in), .transceiver_ctrl_wr(wr_v[5]), .transceiver_disable_in(txd),
    .dev_state_r(state), .irq_status_r(st_r), .irq_mask_r(mask_r), .irq_r(irq),
    .addressed_state_enable_r(aen_r), .configured_r(cfg_r), .function_address_r(fa_r),
    .function_enable_r(fen_r), .endpoint_enable_r(een_r), .endpoint_type_r(ety_r),
    .transceiver_disable_r(txd_r), .tok_accept_r(acc));
  task stop_test();
    $display("checks %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle strobe; value lands at the edge that drops it
  task wr(input int b);
    @(posedge clk);
    wr_v[b] <= 1'b1;
    @(posedge clk);
    wr_v <= 6'h00;
    @(negedge clk);
  endtask : wr
  task tok(input logic [6:0] a, input logic exp);
    host_u.token(a);
    @(negedge clk);
    chk("token accept", {11'h0, exp}, {11'h0, acc});
  endtask : tok
  task wait_state(input dev_state_t s);
    for (int i = 0; i < 40 && state !== s; i++) @(negedge clk);
    chk("state", {9'h0, s}, {9'h0, state});
  endtask : wait_state
  task bus_reset_end();
    host_u.bus_reset();
    wait_state(ST_DEFAULT);
    chk("bus reset end flag", 12'h001, {11'h0, st_r[2]});
    @(negedge clk);
    chk("unmasked irq", 12'h001, {11'h0, irq});
    chk("mask after reset", 12'h000, {9'h0, mask_r});
    chk("endpoints after reset", 12'h000, {8'h0, een_r});
    chk("address regs after reset", 12'h000, {3'h0, aen_r, fen_r, fa_r});
  endtask : bus_reset_end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk("reset state", 12'h000, {9'h0, state});
    chk("reset transceiver off", 12'h001, {11'h0, txd_r});
    bus_reset_end();
    @(posedge clk);
    txd <= 1'b0;
    wr(5);
    chk("transceiver enabled", 12'h000, {11'h0, txd_r});
    tok(7'h00, 1'b1);
    tok(7'h05, 1'b0);
    @(posedge clk);
    clr_in <= 3'h4;
    wr(4);
    chk("bus reset end flag cleared", 12'h000, {11'h0, st_r[2]});
    tok(7'h00, 1'b1); // status stage on address zero finishes before the commit
    @(posedge clk);
    aen <= 1'b1;
    fa <= 7'h05;
    function_enable <= 1'b1;
    wr(0);
    wr(1);
    chk("address regs", 12'h185, {3'h0, aen_r, fen_r, fa_r});
    wait_state(ST_ADDRESS);
    tok(7'h05, 1'b1);
    tok(7'h00, 1'b0);
    @(posedge clk);
    cfg <= 1'b1;
    wr(0);
    chk("configured bit", 12'h001, {11'h0, cfg_r});
    @(posedge clk);
    esel <= 2'h1;
    een <= 1'b1;
    etype <= 3'h6;
    wr(2);
    chk("ep1 enable", 12'h002, {8'h0, een_r});
    chk("ep1 type", 12'h006, {9'h0, ety_r[5:3]});
    wait_state(ST_CONFIGURED);
    @(posedge clk);
    mask_in <= 3'h1;
    wr(3);
    host_u.set_activity(1'b0);
    for (int i = 0; i < 60 && st_r[0] !== 1'b1; i++) @(negedge clk);
    chk("suspend flag", 12'h001, {11'h0, st_r[0]});
    @(negedge clk);
    chk("suspend irq", 12'h001, {11'h0, irq});
    @(posedge clk);
    clr_in <= 3'h1;
    wr(4);
    chk("suspend flag cleared", 12'h000, {11'h0, st_r[0]});
    chk("suspended", {9'h0, ST_SUSPENDED}, {9'h0, state});
    @(posedge clk);
    txd <= 1'b1;
    wr(5);
    chk("transceiver off", 12'h001, {11'h0, txd_r});
    @(posedge clk);
    mce <= 1'b0; // clock stopped only after the writes above
    mask_in <= 3'h7;
    wr(3);
    chk("mask with clock off", 12'h001, {9'h0, mask_r});
    host_u.set_activity(1'b1);
    wait_state(ST_CONFIGURED);
    chk("resume flag", 12'h001, {11'h0, st_r[1]});
    @(posedge clk);
    mce <= 1'b1;
    txd <= 1'b0;
    wr(5);
    chk("transceiver on", 12'h000, {11'h0, txd_r});
    bus_reset_end();
    stop_test();
  end
  // the sequence needs well under a thousand cycles
  initial begin
    #(50 * 5000);
    fails++;
    stop_test();
  end
endmodule : usb_device_state_control_tb_top
`default_nettype wire
